// file: wake_event_status_enable_test.sv
// self-checking bench for the wake event block
// assumes wsen_top and wsen_host_model are compiled before it
`timescale 1ns/1ps
`default_nettype none
module wake_event_status_enable_test;
	import wsen_pkg::*;
	logic clk, rst, wr, rd, ri1_n, ri2_n, wdog, pin30, wake_n, irq, irq_a;
	logic [7:0] addr;
	wsen_byte_t wdata, rdata;
	logic [3:0] pin20;
	logic [6:0] pin31;
	int error_cnt, n_compared, wakes;
	wsen_top dut (.i_clk_sys(clk), .i_rst(rst), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.i_ring_indicate_first_n(ri1_n),
		.i_ring_indicate_second_or_pin50(ri2_n), .i_pin20_23(pin20),
		.i_watchdog_wake_source(wdog), .i_pin30_or_ring_indicate_third(pin30),
		.i_pin31_37(pin31), .o_wake_request_out_n(wake_n), .o_irq(irq));
	wsen_host_model host (.i_clk_sys(clk), .i_rst(rst),
		.i_wake_request_out_n(wake_n), .o_wake_count(wakes));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic summarize;
		$display("errors %0d compared %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : summarize
	task automatic chk(input wsen_byte_t seen, input wsen_byte_t exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic wreg(input logic [7:0] a, input wsen_byte_t d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	// read data stand only in the cycle after the strobe
	task automatic rchk(input logic [7:0] a, input wsen_byte_t exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask : rchk
	initial begin
		#50000;
		error_cnt++;
		summarize();
	end
	initial begin
		{rst, wr, rd, addr, wdata, wdog, pin30, pin20, pin31} = '0;
		rst = 1'b1;
		{ri1_n, ri2_n} = 2'b11;
		error_cnt = 0;
		n_compared = 0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		for (int i = 3; i <= 6; i++) rchk(8'(i), 8'h00);
		wreg(8'h05, 8'hA5);
		wreg(8'h06, 8'hFF);
		rchk(8'h05, 8'hA5);
		rchk(8'h06, 8'hBF);
		wreg(8'h06, 8'h00);
		// every source fires at once while enable two, the master enable and the interrupt mask are zero
		@(posedge clk);
		{ri1_n, ri2_n, wdog, pin30} <= 4'h3;
		pin20 <= 4'hF;
		pin31 <= 7'h7F;
		tick(3);
		rchk(8'h03, 8'hBF);
		rchk(8'h04, 8'hFF);
		wreg(8'h01, 8'h01);
		tick(2);
		chk({7'h00, wake_n}, 8'h01);
		wreg(8'h06, 8'h04);
		tick(2);
		chk({7'h00, wake_n}, 8'h00);
		chk(8'(wakes), 8'h01);
		wreg(8'h03, 8'h00);
		rchk(8'h03, 8'hBF);
		wreg(8'h04, 8'h0F);
		rchk(8'h04, 8'hF0);
		wreg(8'h01, 8'h00);
		tick(2);
		chk({7'h00, wake_n}, 8'h01);
		rchk(8'h00, 8'h01);
		wreg(8'h03, 8'hFF);
		wreg(8'h00, 8'h01);
		rchk(8'h00, 8'h00);
		wreg(8'h01, 8'h01);
		tick(2);
		chk({7'h00, wake_n}, 8'h01);
		// mask polarity is the designer's; only one setting may raise it
		wreg(8'h21, 8'h00);
		tick(2);
		irq_a = irq;
		wreg(8'h21, 8'h07);
		tick(2);
		chk({7'h00, irq ^ irq_a}, 8'h01);
		wreg(8'h20, 8'h07);
		rchk(8'h20, 8'h00);
		tick(2);
		chk({7'h00, irq}, 8'h00);
		wreg(8'h40, 8'hFF);
		rchk(8'h40, 8'h00);
		// sources go idle first, or their level reads as a fresh edge
		@(posedge clk);
		{ri1_n, ri2_n, wdog, pin30} <= 4'hC;
		pin20 <= 4'h0;
		pin31 <= 7'h00;
		@(posedge clk);
		rst <= 1'b1;
		tick(2);
		rst <= 1'b0;
		rchk(8'h05, 8'h00);
		rchk(8'h04, 8'h00);
		summarize();
	end
endmodule : wake_event_status_enable_test
`default_nettype wire

// file: wsen_defines.svh
// register offsets, field positions and reset values of the wake event block
// assumes a byte-wide register port with 8-bit addresses
`ifndef WSEN_DEFINES_SVH
`define WSEN_DEFINES_SVH
`define WSEN_OFS_MASTER_FLAG 8'h00
`define WSEN_OFS_MASTER_EN 8'h01
`define WSEN_OFS_STATUS_TWO 8'h03
`define WSEN_OFS_STATUS_THREE 8'h04
`define WSEN_OFS_ENABLE_ONE 8'h05
`define WSEN_OFS_ENABLE_TWO 8'h06
`define WSEN_OFS_IRQ_STATUS 8'h20
`define WSEN_OFS_IRQ_MASK 8'h21
`define WSEN_RST_VALUE 8'h00
`define WSEN_BIT_RESERVED_TWO 6
`define WSEN_BIT_WATCHDOG 7
`define WSEN_MASK_STATUS_TWO 8'hBF
`define WSEN_IRQ_BIT_FLAG 0
`define WSEN_IRQ_BIT_STS2 1
`define WSEN_IRQ_BIT_STS3 2
`define WSEN_IRQ_MASK_VALID 8'h07
`endif

// file: wsen_host_model.sv
// host-side model of the chipset wake input
// assumes an active-low level request sampled on the system clock
`timescale 1ns/1ps
`default_nettype none
module wsen_host_model (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_wake_request_out_n,
	output var int o_wake_count
);
	logic prev_n;
	// a held request counts once: the host reacts to a new assertion only
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			prev_n <= 1'b1;
			o_wake_count <= 0;
		end else begin
			prev_n <= i_wake_request_out_n;
			if (prev_n && !i_wake_request_out_n) begin
				o_wake_count <= o_wake_count + 1;
			end
		end
	end
endmodule : wsen_host_model
`default_nettype wire

// file: wsen_pkg.sv
// types shared by the wake event block
// assumes nothing beyond a SystemVerilog compiler
package wsen_pkg;
	typedef logic [7:0] wsen_byte_t;
endpackage : wsen_pkg

// file: wsen_top.sv
// wake event status and enable logic with its register port
// i_rst is the standby-power power-on reset; main-power resets never reach it
// Operation
// - status bits latch events regardless of source enable or master enable
// - an event sets its status bit, which holds until software clears it
// - writing one to a status bit clears it; writing zero does nothing
// - pin events set status whatever alternate function the pin has
// - wake request drives when enable, status and master enable are all one
// - disabled source still records status but never drives the request
// - status registers clear only at standby-power power-on reset
// - enable registers clear only at standby-power power-on reset
// - master enable bit 0 must be one before the request can drive
// - writing one to the master flag clears it only while no enabled status bit is set, and drops the request for one cycle
//
// Design decision made here: the address-and-strobe port.
`include "wsen_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module wsen_top (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic [7:0] i_addr,
	input wire wsen_pkg::wsen_byte_t i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output wsen_pkg::wsen_byte_t o_rdata,
	input wire logic i_ring_indicate_first_n,
	input wire logic i_ring_indicate_second_or_pin50,
	input wire logic [3:0] i_pin20_23,
	input wire logic i_watchdog_wake_source,
	input wire logic i_pin30_or_ring_indicate_third,
	input wire logic [6:0] i_pin31_37,
	output logic o_wake_request_out_n,
	output logic o_irq
);
	import wsen_pkg::*;

	wsen_byte_t status_two;
	wsen_byte_t status_three;
	wsen_byte_t enable_one;
	wsen_byte_t enable_two;
	logic wake_master_enable;
	logic wake_master_flag;
	wsen_byte_t irq_status;
	wsen_byte_t irq_mask;
	wsen_byte_t event_two;
	wsen_byte_t event_three;
	wsen_byte_t prev_two;
	wsen_byte_t prev_three;
	wsen_byte_t raw_two;
	wsen_byte_t raw_three;
	logic wake_cond;
	logic wr_sts2;
	logic wr_sts3;
	logic wr_flag;
	wsen_byte_t next_irq_status;

	// the two ring inputs of status two are active low; pins, watchdog and the pin 30 / third ring input are taken as active high
	assign raw_two = {i_watchdog_wake_source, 1'b0, i_pin20_23,
		~i_ring_indicate_second_or_pin50, ~i_ring_indicate_first_n};
	assign raw_three = {i_pin31_37, i_pin30_or_ring_indicate_third};

	// a wake event is the rising edge of the source level
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			prev_two <= `WSEN_RST_VALUE;
			prev_three <= `WSEN_RST_VALUE;
		end else begin
			prev_two <= raw_two;
			prev_three <= raw_three;
		end
	end

	assign event_two = raw_two & ~prev_two & `WSEN_MASK_STATUS_TWO;
	assign event_three = raw_three & ~prev_three;
	assign wr_sts2 = i_wr && (i_addr == `WSEN_OFS_STATUS_TWO);
	assign wr_sts3 = i_wr && (i_addr == `WSEN_OFS_STATUS_THREE);
	assign wr_flag = i_wr && (i_addr == `WSEN_OFS_MASTER_FLAG);

	// set wins over a clear landing in the same cycle
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			status_two <= `WSEN_RST_VALUE;
			status_three <= `WSEN_RST_VALUE;
		end else begin
			status_two <= ((status_two & ~(wr_sts2 ? i_wdata : 8'h00))
				| event_two) & `WSEN_MASK_STATUS_TWO;
			status_three <= (status_three & ~(wr_sts3 ? i_wdata : 8'h00))
				| event_three;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			enable_one <= `WSEN_RST_VALUE;
			enable_two <= `WSEN_RST_VALUE;
			wake_master_enable <= 1'b0;
			irq_mask <= `WSEN_RST_VALUE;
		end else if (i_wr) begin
			case (i_addr)
				`WSEN_OFS_ENABLE_ONE: enable_one <= i_wdata;
				`WSEN_OFS_ENABLE_TWO: enable_two <= i_wdata & `WSEN_MASK_STATUS_TWO;
				`WSEN_OFS_MASTER_EN: wake_master_enable <= i_wdata[0];
				`WSEN_OFS_IRQ_MASK: irq_mask <= i_wdata & `WSEN_IRQ_MASK_VALID;
				default: ;
			endcase
		end
	end

	// enable one covers sources outside this block, so it steers nothing here;
	// status three's enable lives outside too, so only status two can wake
	assign wake_cond = |(status_two & enable_two);

	// the master flag records would-assert state independent of the master enable
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			wake_master_flag <= 1'b0;
		end else if (wake_cond) begin
			wake_master_flag <= 1'b1;
		end else if (wr_flag && i_wdata[0]) begin
			wake_master_flag <= 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_wake_request_out_n <= 1'b1;
		end else begin
			o_wake_request_out_n <= ~(wake_cond && wake_master_enable
				&& !(wr_flag && i_wdata[0]));
		end
	end

	always_comb begin
		next_irq_status = irq_status;
		if (i_wr && (i_addr == `WSEN_OFS_IRQ_STATUS)) begin
			next_irq_status = irq_status & ~i_wdata;
		end
		next_irq_status[`WSEN_IRQ_BIT_FLAG] = next_irq_status[`WSEN_IRQ_BIT_FLAG]
			| (wake_cond & ~wake_master_flag);
		next_irq_status[`WSEN_IRQ_BIT_STS2] = next_irq_status[`WSEN_IRQ_BIT_STS2]
			| (|event_two);
		next_irq_status[`WSEN_IRQ_BIT_STS3] = next_irq_status[`WSEN_IRQ_BIT_STS3]
			| (|event_three);
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			irq_status <= `WSEN_RST_VALUE;
			o_irq <= 1'b0;
		end else begin
			irq_status <= next_irq_status & `WSEN_IRQ_MASK_VALID;
			o_irq <= |(next_irq_status & irq_mask);
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= `WSEN_RST_VALUE;
		end else if (i_rd) begin
			case (i_addr)
				`WSEN_OFS_MASTER_FLAG: o_rdata <= {7'h00, wake_master_flag};
				`WSEN_OFS_MASTER_EN: o_rdata <= {7'h00, wake_master_enable};
				`WSEN_OFS_STATUS_TWO: o_rdata <= status_two;
				`WSEN_OFS_STATUS_THREE: o_rdata <= status_three;
				`WSEN_OFS_ENABLE_ONE: o_rdata <= enable_one;
				`WSEN_OFS_ENABLE_TWO: o_rdata <= enable_two;
				`WSEN_OFS_IRQ_STATUS: o_rdata <= irq_status;
				`WSEN_OFS_IRQ_MASK: o_rdata <= irq_mask;
				default: o_rdata <= 8'h00;
			endcase
		end else begin
			o_rdata <= 8'h00;
		end
	end

	sequence s_event_two;
		|event_two;
	endsequence

	sequence s_no_clear_two;
		!wr_sts2;
	endsequence

	a_status_sets_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		s_event_two ##1 s_no_clear_two |-> ((status_two & $past(event_two)) ==
			$past(event_two)))
		else $error("status two event not latched");
	a_status_ignores_enable: assert property (@(posedge i_clk_sys)
		disable iff (i_rst) |event_three |=> ((status_three &
			$past(event_three)) == $past(event_three)))
		else $error("status three event lost");
	a_clear_by_one: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		wr_sts2 && !(|event_two) |=>
			((status_two & $past(i_wdata)) == 8'h00))
		else $error("write one did not clear status");
	a_zero_write_keeps: assert property (@(posedge i_clk_sys)
		disable iff (i_rst) wr_sts3 |=>
			((status_three & ~$past(i_wdata)) == (($past(status_three) &
			~$past(i_wdata)) | ($past(event_three) & ~$past(i_wdata)))))
		else $error("zero write changed status");
	a_request_drives: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		wake_cond && wake_master_enable && !wr_flag |=>
			!o_wake_request_out_n)
		else $error("wake request not driven");
	a_master_gate: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		!wake_master_enable |=> o_wake_request_out_n)
		else $error("request driven without master enable");
	a_disabled_quiet: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(status_two & enable_two) == 8'h00 |=> o_wake_request_out_n)
		else $error("disabled source drove request");
	a_flag_clear_drop: assert property (@(posedge i_clk_sys)
		disable iff (i_rst) wr_flag && i_wdata[0] |=>
			o_wake_request_out_n)
		else $error("request stayed after flag clear");
	a_reserved_zero: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		!status_two[`WSEN_BIT_RESERVED_TWO] && !enable_two[6])
		else $error("reserved bit set");
	a_enable_holds: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		!(i_wr && i_addr == `WSEN_OFS_ENABLE_TWO) |=>
			enable_two == $past(enable_two))
		else $error("enable changed without write");
	a_status_no_spont: assert property (@(posedge i_clk_sys)
		disable iff (i_rst) !wr_sts3 && !(|event_three) |=>
			status_three == $past(status_three))
		else $error("status changed without cause");

	sequence s_event_three;
		|event_three;
	endsequence

	sequence s_no_clear_three;
		!wr_sts3;
	endsequence

	a_status_three_hold: assert property (@(posedge i_clk_sys)
		disable iff (i_rst) s_event_three ##1 s_no_clear_three |->
			((status_three & $past(event_three)) == $past(event_three)))
		else $error("status three event not held");
	a_clear_three_one: assert property (@(posedge i_clk_sys)
		disable iff (i_rst) wr_sts3 && !(|event_three) |=>
			((status_three & $past(i_wdata)) == 8'h00))
		else $error("write one did not clear status three");
	a_zero_keeps_two: assert property (@(posedge i_clk_sys)
		disable iff (i_rst) wr_sts2 |=>
			((status_two & ~$past(i_wdata)) == (($past(status_two)
			| $past(event_two)) & ~$past(i_wdata))))
		else $error("zero write changed status two");
	a_status_two_still: assert property (@(posedge i_clk_sys)
		disable iff (i_rst) !wr_sts2 && !(|event_two) |=>
			status_two == $past(status_two))
		else $error("status two changed without cause");

	// a pin edge must land whatever the pin is otherwise used for
	a_pin30_event: assert property (@(posedge i_clk_sys)
		disable iff (i_rst) $rose(i_pin30_or_ring_indicate_third) |=>
			status_three[0])
		else $error("pin 30 edge not recorded");
	a_ring_event: assert property (@(posedge i_clk_sys)
		disable iff (i_rst) $fell(i_ring_indicate_first_n) |=> status_two[0])
		else $error("ring indicate edge not recorded");
	a_watchdog_event: assert property (@(posedge i_clk_sys)
		disable iff (i_rst) $rose(i_watchdog_wake_source) |=> status_two[7])
		else $error("watchdog edge not recorded");

	a_enable_one_holds: assert property (@(posedge i_clk_sys)
		disable iff (i_rst) !(i_wr && i_addr == `WSEN_OFS_ENABLE_ONE) |=>
			enable_one == $past(enable_one))
		else $error("enable one changed without write");
	a_enable_one_write: assert property (@(posedge i_clk_sys)
		disable iff (i_rst) i_wr && i_addr == `WSEN_OFS_ENABLE_ONE |=>
			enable_one == $past(i_wdata))
		else $error("enable one write lost");
	a_enable_two_write: assert property (@(posedge i_clk_sys)
		disable iff (i_rst) i_wr && i_addr == `WSEN_OFS_ENABLE_TWO |=>
			enable_two == ($past(i_wdata) & `WSEN_MASK_STATUS_TWO))
		else $error("enable two write wrong");
	a_master_en_holds: assert property (@(posedge i_clk_sys)
		disable iff (i_rst) !(i_wr && i_addr == `WSEN_OFS_MASTER_EN) |=>
			wake_master_enable == $past(wake_master_enable))
		else $error("master enable changed without write");

	// the flag records would-assert state even with the master enable off
	a_flag_sets: assert property (@(posedge i_clk_sys)
		disable iff (i_rst) wake_cond |=> wake_master_flag)
		else $error("master flag not set");
	a_flag_clears: assert property (@(posedge i_clk_sys)
		disable iff (i_rst) wr_flag && i_wdata[0] && !wake_cond |=>
			!wake_master_flag)
		else $error("master flag not cleared");
	a_flag_keeps: assert property (@(posedge i_clk_sys)
		disable iff (i_rst) !wake_cond && !(wr_flag && i_wdata[0]) |=>
			wake_master_flag == $past(wake_master_flag))
		else $error("master flag changed without cause");
	a_request_cause: assert property (@(posedge i_clk_sys)
		disable iff (i_rst) !o_wake_request_out_n |->
			$past(wake_cond) && $past(wake_master_enable))
		else $error("request driven without cause");

	a_read_idle_zero: assert property (@(posedge i_clk_sys)
		disable iff (i_rst) !i_rd |=> o_rdata == 8'h00)
		else $error("read data not zero when idle");
	a_read_status_two: assert property (@(posedge i_clk_sys)
		disable iff (i_rst) i_rd && i_addr == `WSEN_OFS_STATUS_TWO |=>
			o_rdata == $past(status_two))
		else $error("status two read wrong");
	a_irq_masked_off: assert property (@(posedge i_clk_sys)
		disable iff (i_rst) irq_mask == 8'h00 |=> !o_irq)
		else $error("interrupt raised while fully masked");
endmodule : wsen_top
`default_nettype wire
